/* src/sarhs_corr_mem.sv */
// correction-factor store written by calibration, read during conversion
// assumes one clock; read data appear one edge after the address
`timescale 1ns/10ps
module sarhs_corr_mem #(
    parameter int WIDTH = 13,
    parameter int DEPTH = 16,
    parameter int AW = 4
) (
    input wire logic mclk,
    input wire logic we,
    input wire logic [AW-1:0] waddr,
    input wire logic [WIDTH-1:0] wdata,
    input wire logic [AW-1:0] raddr,
    output logic [WIDTH-1:0] rdata
);
    logic [WIDTH-1:0] mem [DEPTH];

    always_ff @(posedge mclk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
        rdata <= mem[raddr];
    end
endmodule

/* src/sarhs_pkg.sv */
// constants, state codes and register layout of the converter sequencer
// assumes one 10 MHz clock; every host pin arrives asynchronously
// Behaviour
// - write-started acquisition ends six to seven conversion clocks after write rises
// - with clock falling at write rise, acquisition ends six and a half clocks later
// - chip select low enables read, write and sample/hold; otherwise they are ignored
// - select and read low drive the byte bus and raise the flag
// - write rising edge with select low starts a conversion, acquisition timed internally
// - sample/hold fall opens acquisition, its rise holds and starts conversion
// - calibration request low resets and runs calibration storing correction values
// - offset-null low inserts a 26-clock offset-null cycle before a write-started conversion
// - end-of-conversion stays low during conversion or calibration
// - completion flag goes low when the result is latched
// - completion flag goes high on read, new conversion or calibration
// - result read as two bytes, upper byte first
// - two's complement, sign in bit twelve, sign copied into upper byte
// - end-of-conversion low for the 1399-clock calibration after request falls
// - calibration finds and stores offset, then finds and stores twelve mismatch corrections
// - after offset-null, acquisition runs about seven clocks
// - without offset-null, acquisition opens when end-of-conversion rises
// - end-of-conversion falls when acquisition closes and approximation starts
// - write conversion takes 27 clocks, sample/hold conversion 34 clocks
// - a running calibration cannot be aborted by any input but nrst, which restarts it
// - first step compares against ground: sign 0 positive, 1 negative
package sarhs_pkg;
    localparam int NPIN = 8;
    localparam int PIN_CS = 0;
    localparam int PIN_RD = 1;
    localparam int PIN_WR = 2;
    localparam int PIN_SH = 3;
    localparam int PIN_CAL = 4;
    localparam int PIN_NULL = 5;
    localparam int PIN_CK = 6;
    localparam int PIN_CMP = 7;
    localparam logic [NPIN-1:0] PIN_IDLE = 8'h3f;

    localparam int RES_W = 13;
    localparam int BYTE_W = 8;
    localparam int SIGN_BIT = 12;
    localparam int HI_LSB = 8;
    localparam int HI_MAG_W = 4;
    localparam int SIGN_EXT_W = 4;
    localparam logic [RES_W-1:0] DAC_MSB = 13'h0800;
    localparam logic [RES_W-1:0] ACC_UP = 13'h0001;
    localparam logic [RES_W-1:0] ACC_DOWN = 13'h1fff;

    localparam int CNT_W = 11;
    localparam logic [CNT_W-1:0] ACQ_CLKS = 11'h007;
    localparam logic [CNT_W-1:0] NULL_CLKS = 11'h01a;
    localparam logic [CNT_W-1:0] CONV_WR_CLKS = 11'h01b;
    localparam logic [CNT_W-1:0] CONV_SH_CLKS = 11'h022;
    localparam logic [CNT_W-1:0] CAL_CLKS = 11'h577;
    localparam logic [CNT_W-1:0] CAL_OFS_CLKS = 11'h080;
    localparam int SEG_SH = 6;
    localparam int SAR_BITS = 12;
    localparam logic [CNT_W-1:0] CAL_MIS_END = 11'h380;

    localparam int MEM_AW = 4;
    localparam int MEM_DEPTH = 16;
    localparam logic [MEM_AW-1:0] ADDR_OFS = 4'h0;

    typedef enum logic [5:0] {
        ST_IDLE  = 6'b000001,
        ST_CAL   = 6'b000010,
        ST_NULL  = 6'b000100,
        ST_ACQ   = 6'b001000,
        ST_SHACQ = 6'b010000,
        ST_CONV  = 6'b100000
    } sarhs_state_type;

    typedef struct packed {
        logic [NPIN-1:0] s1;
        logic [NPIN-1:0] s2;
        logic [NPIN-1:0] s3;
        logic [NPIN-1:0] lvl;
        sarhs_state_type state;
        logic [CNT_W-1:0] cnt;
        logic by_write;
        logic [RES_W-1:0] sar;
        logic [RES_W-1:0] result;
        logic [RES_W-1:0] acc;
        logic [RES_W-1:0] dac;
        logic upper_sel;
        logic int_n;
        logic eoc;
        logic track;
        logic [BYTE_W-1:0] bus_d;
        logic bus_oe;
        logic we;
        logic [MEM_AW-1:0] waddr;
        logic [RES_W-1:0] wdata;
    } sarhs_regs_type;
endpackage

/* src/sarhs_seq.sv */
// sequencer of the sign-plus-12-bit converter behind its parallel host pins
// assumes host strobes, conversion clock and comparator arrive asynchronously
`timescale 1ns/10ps
module sarhs_seq
    import sarhs_pkg::*;
(
    input wire logic mclk,
    input wire logic nrst,
    input wire logic cs_n,
    input wire logic rd_n,
    input wire logic wr_n,
    input wire logic sh_n,
    input wire logic cal_n,
    input wire logic offset_null_n,
    input wire logic conversion_clock_in,
    input wire logic comp_gt,
    output logic eoc,
    output logic int_n,
    output logic [BYTE_W-1:0] result_byte_bus_o,
    output logic result_byte_bus_oe,
    output logic track,
    output logic [RES_W-1:0] dac_code
);
    localparam sarhs_regs_type REGS_RESET = '{
        s1: PIN_IDLE,
        s2: PIN_IDLE,
        s3: PIN_IDLE,
        lvl: PIN_IDLE,
        state: ST_CAL,
        cnt: '0,
        by_write: 1'b0,
        sar: '0,
        result: '0,
        acc: '0,
        dac: '0,
        upper_sel: 1'b1,
        int_n: 1'b1,
        eoc: 1'b0,
        track: 1'b0,
        bus_d: '0,
        bus_oe: 1'b0,
        we: 1'b0,
        waddr: '0,
        wdata: '0
    };

    sarhs_regs_type r;
    sarhs_regs_type n;
    logic [NPIN-1:0] pins;
    logic [NPIN-1:0] rise;
    logic [NPIN-1:0] fall;
    logic cs_on;
    logic ck;
    logic rd_act;
    logic wr_start;
    logic sh_open;
    logic sh_close;
    logic cal_start;
    logic comp;
    logic [RES_W-1:0] acc_nx;
    logic [CNT_W-1:0] cnt_nx;
    logic [CNT_W-1:0] conv_len;
    logic [CNT_W-1:0] cal_off;
    logic [CNT_W-1:0] seg_full;
    logic [MEM_AW-1:0] seg;
    logic [MEM_AW-1:0] raddr;
    logic [RES_W-1:0] rdata;
    int b;

    assign pins = {comp_gt, conversion_clock_in, offset_null_n, cal_n, sh_n, wr_n, rd_n, cs_n};

    sarhs_corr_mem #(
        .WIDTH(RES_W),
        .DEPTH(MEM_DEPTH),
        .AW(MEM_AW)
    ) u_corr (
        .mclk(mclk),
        .we(r.we),
        .waddr(r.waddr),
        .wdata(r.wdata),
        .raddr(raddr),
        .rdata(rdata)
    );

    always_comb begin
        n = r;
        n.we = 1'b0;
        // three-stage pin synchronisers, level accepted once stages two and three agree
        n.s1 = pins;
        n.s2 = r.s1;
        n.s3 = r.s2;
        for (int i = 0; i < NPIN; i++) begin
            if (r.s2[i] == r.s3[i]) begin
                n.lvl[i] = r.s3[i];
            end
        end
        rise = n.lvl & ~r.lvl;
        fall = ~n.lvl & r.lvl;
        cs_on = ~r.lvl[PIN_CS];
        ck = rise[PIN_CK];
        comp = r.lvl[PIN_CMP];
        rd_act = cs_on & ~r.lvl[PIN_RD];
        wr_start = rise[PIN_WR] & cs_on;
        sh_open = fall[PIN_SH] & cs_on;
        sh_close = rise[PIN_SH] & cs_on;
        cal_start = fall[PIN_CAL];
        cnt_nx = r.cnt + 11'h001;
        acc_nx = comp ? r.acc + ACC_UP : r.acc + ACC_DOWN;
        conv_len = r.by_write ? CONV_WR_CLKS - ACQ_CLKS : CONV_SH_CLKS;
        cal_off = r.cnt - CAL_OFS_CLKS;
        seg_full = cal_off >> SEG_SH;
        seg = seg_full[MEM_AW-1:0];
        b = SAR_BITS - int'(r.cnt);
        raddr = ADDR_OFS;
        if (r.state == ST_CONV && r.cnt <= CNT_W'(SAR_BITS)) begin
            raddr = r.cnt[MEM_AW-1:0];
        end

        // read port: bus driven only while select and read are low
        n.bus_oe = rd_act;
        n.bus_d = r.upper_sel ? {{SIGN_EXT_W{r.result[SIGN_BIT]}}, r.result[HI_LSB +: HI_MAG_W]}
                              : r.result[BYTE_W-1:0];
        if (rd_act && !r.bus_oe) begin
            n.int_n = 1'b1;
        end
        if (!rd_act && r.bus_oe) begin
            n.upper_sel = ~r.upper_sel;
        end

        if (r.state == ST_CAL) begin
            // calibration runs to its end whatever the pins do
            if (ck) begin
                n.cnt = cnt_nx;
                if (r.cnt < CAL_OFS_CLKS) begin
                    n.dac = '0;
                    n.acc = acc_nx;
                    if (r.cnt == CAL_OFS_CLKS - 11'h001) begin
                        n.we = 1'b1;
                        n.waddr = ADDR_OFS;
                        n.wdata = acc_nx;
                        n.acc = '0;
                    end
                end else if (r.cnt < CAL_MIS_END) begin
                    n.dac = DAC_MSB >> seg;
                    n.acc = acc_nx;
                    if (cal_off[SEG_SH-1:0] == '1) begin
                        n.we = 1'b1;
                        n.waddr = seg + 4'h1;
                        n.wdata = acc_nx;
                        n.acc = '0;
                    end
                end else begin
                    n.dac = '0;
                end
                if (r.cnt == CAL_CLKS - 11'h001) begin
                    n.state = ST_IDLE;
                    n.eoc = 1'b1;
                    n.track = 1'b1;
                    n.cnt = '0;
                end
            end
        end else if (cal_start) begin
            n.state = ST_CAL;
            n.cnt = '0;
            n.acc = '0;
            n.eoc = 1'b0;
            n.track = 1'b0;
            n.int_n = 1'b1;
        end else if (wr_start) begin
            n.by_write = 1'b1;
            n.cnt = '0;
            n.int_n = 1'b1;
            if (!r.lvl[PIN_NULL]) begin
                n.state = ST_NULL;
                n.track = 1'b0;
            end else begin
                n.state = ST_ACQ;
                n.track = 1'b1;
            end
        end else if (sh_open) begin
            n.state = ST_SHACQ;
            n.track = 1'b1;
            n.int_n = 1'b1;
        end else if (sh_close && r.state == ST_SHACQ) begin
            n.state = ST_CONV;
            n.by_write = 1'b0;
            n.cnt = '0;
            n.sar = '0;
            n.track = 1'b0;
            n.eoc = 1'b0;
        end else begin
            unique case (r.state)
                ST_IDLE: begin
                    n.dac = '0;
                end
                ST_CAL: begin
                    n.cnt = r.cnt;
                end
                ST_NULL: begin
                    if (ck) begin
                        n.cnt = cnt_nx;
                        if (r.cnt == NULL_CLKS - 11'h001) begin
                            n.state = ST_ACQ;
                            n.cnt = '0;
                            n.track = 1'b1;
                        end
                    end
                end
                ST_ACQ: begin
                    // counted from write rise or from the end of offset-null: ends on the seventh conversion clock rise
                    if (ck) begin
                        n.cnt = cnt_nx;
                        if (r.cnt == ACQ_CLKS - 11'h001) begin
                            n.state = ST_CONV;
                            n.cnt = '0;
                            n.sar = '0;
                            n.track = 1'b0;
                            n.eoc = 1'b0;
                        end
                    end
                end
                ST_SHACQ: begin
                    n.track = 1'b1;
                end
                ST_CONV: begin
                    n.dac = r.sar + rdata;
                    if (ck) begin
                        n.cnt = cnt_nx;
                        if (r.cnt == '0) begin
                            n.sar = {~comp, DAC_MSB[SAR_BITS-1:0]};
                        end else if (b >= 0) begin
                            if (!comp) begin
                                n.sar[b] = 1'b0;
                            end
                            if (b > 0) begin
                                n.sar[b - 1] = 1'b1;
                            end
                        end
                        if (r.cnt == conv_len - 11'h001) begin
                            n.state = ST_IDLE;
                            n.result = r.sar;
                            n.int_n = 1'b0;
                            n.eoc = 1'b1;
                            n.track = 1'b1;
                            n.upper_sel = 1'b1;
                            n.cnt = '0;
                        end
                    end
                end
            endcase
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            r <= REGS_RESET;
        end else begin
            r <= n;
        end
    end

    assign eoc = r.eoc;
    assign int_n = r.int_n;
    assign result_byte_bus_o = r.bus_d;
    assign result_byte_bus_oe = r.bus_oe;
    assign track = r.track;
    assign dac_code = r.dac;
endmodule

/* verif/sarhs_host.sv */
// host model: select, strobes and calibration request, plus the conversion clock
// assumes one caller at a time; a start with m[1] clear leaves select low until the next read, calibration request or start with m[1] set
`timescale 1ns/10ps
module sarhs_host (
    input wire logic mclk,
    input wire logic eoc,
    input wire logic int_n,
    input wire logic [7:0] result_byte_bus_o,
    input wire logic result_byte_bus_oe,
    output logic cs_n,
    output logic rd_n,
    output logic wr_n,
    output logic sh_n,
    output logic cal_n,
    output logic conversion_clock_in
);
    initial begin
        {cs_n, rd_n, wr_n, sh_n, cal_n} = 5'h1f;
        conversion_clock_in = 1'b0;
        #37;
        forever #200 conversion_clock_in = ~conversion_clock_in;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
    endtask
    // m[0] sample/hold else write, m[1] select high, m[2] no wait for eoc
    task automatic start(input logic [2:0] m);
        if (!m[2])
            while (!eoc) @(posedge mclk);
        @(posedge mclk);
        cal_n <= 1'b1;
        cs_n <= m[1];
        tick(2);
        sh_n <= !m[0];
        wr_n <= m[0];
        tick(m[0] ? 20 : 4);
        sh_n <= 1'b1;
        wr_n <= 1'b1;
    endtask
    task automatic rd(output logic [7:0] b, output logic [1:0] f, input int g);
        @(posedge mclk);
        cs_n <= 1'b0;
        tick(2);
        rd_n <= 1'b0;
        tick(8);
        b = result_byte_bus_o;
        f = {result_byte_bus_oe, int_n};
        rd_n <= 1'b1;
        cs_n <= 1'b1;
        tick(g);
    endtask
    task automatic cal(input int w);
        @(posedge mclk);
        cs_n <= 1'b1;
        sh_n <= 1'b1;
        cal_n <= 1'b0;
        tick(w);
        cal_n <= 1'b1;
    endtask
endmodule

/* verif/sarhs_seq_sva.sv */
// checker on the sequencer pins
// assumes it is bound to sarhs_seq and the conversion clock runs below mclk/3
`timescale 1ns/10ps
module sarhs_seq_sva
    import sarhs_pkg::*;
(
    input wire logic mclk,
    input wire logic nrst,
    input wire logic cs_n,
    input wire logic rd_n,
    input wire logic cal_n,
    input wire logic conversion_clock_in,
    input wire logic eoc,
    input wire logic int_n,
    input wire logic [BYTE_W-1:0] result_byte_bus_o,
    input wire logic result_byte_bus_oe,
    input wire logic track
);
    logic [1:0] ck_reg;
    logic [10:0] n_reg;
    logic up_reg;
    // conversion clock rises while eoc is low, and the byte selector
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            ck_reg <= 2'h0;
            n_reg <= 11'h000;
            up_reg <= 1'b1;
        end else begin
            ck_reg <= {ck_reg[0], conversion_clock_in};
            n_reg <= eoc ? 11'h000 : n_reg + {10'h000, ck_reg[0] & !ck_reg[1]};
            up_reg <= $fell(int_n) ? 1'b1 : up_reg ^ $fell(result_byte_bus_oe);
        end
    end
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!nrst);
    sequence s_cs_idle; cs_n [*8]; endsequence
    sequence s_done; $rose(eoc); endsequence
    property p_bus_idle; s_cs_idle |-> !result_byte_bus_oe; endproperty
    a_bus_idle: assert property (p_bus_idle) else $error("bus driven unselected");
    property p_rd_flag; $rose(result_byte_bus_oe) |-> int_n && $past(!cs_n && !rd_n, 2); endproperty
    a_rd_flag: assert property (p_rd_flag) else $error("read without flag release");
    property p_flag_src; $rose(int_n) |-> $past(!cs_n || !cal_n, 3); endproperty
    a_flag_src: assert property (p_flag_src) else $error("flag released without cause");
    property p_done; $fell(int_n) |-> s_done; endproperty
    a_done: assert property (p_done) else $error("flag set off completion");
    property p_eoc_max; !eoc |-> n_reg < 11'h57a; endproperty
    a_eoc_max: assert property (p_eoc_max) else $error("eoc low too long");
    property p_cal_len; $rose(eoc) && n_reg > 11'h064 |-> n_reg inside {[11'h575:11'h579]}; endproperty
    a_cal_len: assert property (p_cal_len) else $error("calibration length wrong");
    property p_conv_len;
        $rose(eoc) && n_reg < 11'h064 |-> n_reg inside {[11'h013:11'h015], [11'h021:11'h023]};
    endproperty
    a_conv_len: assert property (p_conv_len) else $error("conversion length wrong");
    property p_acq_open; $rose(eoc) && n_reg < 11'h01e |-> track; endproperty
    a_acq_open: assert property (p_acq_open) else $error("acquisition not open at end");
    property p_close; $fell(eoc) |-> !track; endproperty
    a_close: assert property (p_close) else $error("eoc fell while tracking");
    property p_upper; $rose(result_byte_bus_oe) && up_reg |-> result_byte_bus_o[7:4] inside {4'h0, 4'hf}; endproperty
    a_upper: assert property (p_upper) else $error("upper byte not sign filled");
endmodule

/* verif/sarhs_seq_tb.sv */
// self-checking bench of the converter sequencer with host model
// assumes a full-scale comparator level, so results are 13'h0fff or 13'h1000
`timescale 1ns/10ps
module sarhs_seq_tb
    import sarhs_pkg::*;
;
    logic mclk = 1'b0;
    logic nrst = 1'b0;
    logic offset_null_n = 1'b1;
    logic comp_gt = 1'b1;
    logic cs_n, rd_n, wr_n, sh_n, cal_n, conversion_clock_in;
    logic eoc, int_n, result_byte_bus_oe, track;
    logic [BYTE_W-1:0] result_byte_bus_o;
    logic [RES_W-1:0] dac_code;
    logic [31:0] seed = 32'h564dc43b;
    int failures = 0;
    int n_tests = 0;
    int cyc = 0;
    always #50 mclk = ~mclk;
    sarhs_host i_host (.mclk(mclk), .eoc(eoc), .int_n(int_n), .result_byte_bus_o(result_byte_bus_o),
        .result_byte_bus_oe(result_byte_bus_oe), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n), .sh_n(sh_n),
        .cal_n(cal_n), .conversion_clock_in(conversion_clock_in));
    sarhs_seq i_dut (.mclk(mclk), .nrst(nrst), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n), .sh_n(sh_n),
        .cal_n(cal_n), .offset_null_n(offset_null_n), .conversion_clock_in(conversion_clock_in),
        .comp_gt(comp_gt), .eoc(eoc), .int_n(int_n), .result_byte_bus_o(result_byte_bus_o),
        .result_byte_bus_oe(result_byte_bus_oe), .track(track), .dac_code(dac_code));
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // full-scale result as {upper byte, lower byte}
    function automatic logic [15:0] exp_res(input logic neg);
        logic [12:0] r;
        r = neg ? 13'h1000 : 13'h0fff;
        return {{4{r[SIGN_BIT]}}, r[11:0]};
    endfunction
    task automatic finish_test();
        $display("failures=%0d n_tests=%0d", failures, n_tests);
        if (failures == 0 && n_tests > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chk_rng(input int got, input int lo, input int hi);
        n_tests++;
        if (got < lo || got > hi) begin
            failures++;
            $display("FAIL t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
        end
    endtask
    task automatic wt(input logic v, output int t);
        for (int i = 0; i < 7000 && eoc !== v; i++)
            @(negedge mclk);
        t = cyc;
    endtask
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            failures++;
            finish_test();
        end
    end
    initial begin
        int t0, t1, t2;
        logic [31:0] r;
        logic [15:0] e;
        logic [7:0] b;
        logic [1:0] f;
        repeat (10) @(posedge mclk);
        nrst <= 1'b1;
        wt(1'b1, t1);
        t0 = cyc;
        i_host.cal(8);
        wt(1'b0, t1);
        chk_rng(t1 - t0, 2, 9);
        repeat (1000) @(posedge mclk);
        // about 250 conversion clocks into calibration: second mismatch segment
        chk(16'(dac_code), 16'(DAC_MSB >> 1));
        i_host.start(3'h4);
        i_host.cal(8);
        wt(1'b1, t2);
        chk_rng(t2 - t1, 5590, 5602);
        for (int k = 0; k < 12; k++) begin
            seed = lfsr(seed);
            r = seed;
            if (k < 3) begin
                r[0] = (k == 1);
                r[2] = (k == 2);
                r[3] = (k == 0);
            end
            @(posedge mclk);
            comp_gt <= r[1];
            offset_null_n <= r[0] | r[2];
            if (r[3]) begin
                i_host.start(3'h2);
                i_host.start(3'h3);
                repeat (60) @(negedge mclk);
                chk(eoc, 1'b1);
            end
            i_host.start({2'h0, r[0]});
            t0 = cyc;
            wt(1'b0, t1);
            chk(int_n, 1'b1);
            if (r[0])
                chk_rng(t1 - t0, 1, 7);
            else if (r[2])
                chk_rng(t1 - t0, 24, 34);
            else
                chk_rng(t1 - t0, 128, 138);
            wt(1'b1, t2);
            chk_rng(t2 - t1, r[0] ? 133 : 79, r[0] ? 137 : 81);
            chk(int_n, 1'b0);
            e = exp_res(!r[1]);
            if (r[5:4] != 2'h0) begin
                i_host.rd(b, f, 4 + r[7:6]);
                chk({f, b}, {2'h3, e[15:8]});
            end
            if (r[5]) begin
                i_host.rd(b, f, 4 + r[7:6]);
                chk({f, b}, {2'h3, e[7:0]});
            end
        end
        finish_test();
    end
endmodule
bind sarhs_seq sarhs_seq_sva i_sva (.mclk(mclk), .nrst(nrst), .cs_n(cs_n), .rd_n(rd_n), .cal_n(cal_n),
    .conversion_clock_in(conversion_clock_in), .eoc(eoc), .int_n(int_n), .result_byte_bus_o(result_byte_bus_o),
    .result_byte_bus_oe(result_byte_bus_oe), .track(track));
